/* sqgen_pkg.sv */
// Purpose: Shared constants for the square-wave frequency generator.
// Assumes: 125 MHz system clock, classic Wishbone register access.
// Notes:   Frequency is carried in tenths of a hertz throughout.
package sqgen_pkg;

    // Clock and frequency scaling
    localparam int          CLK_PERIOD_NS      = 8;
    localparam int          CLK_HZ             = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int          FREQ_UNITS_PER_HZ  = 10;
    localparam logic [31:0] FREQ_MIN           = 32'h0000_0001;
    localparam logic [31:0] FREQ_MAX           = 32'h000F_4240;
    // Phase accumulator wraps once per half period
    localparam logic [31:0] ACC_WRAP           = 32'(CLK_HZ / 2 * FREQ_UNITS_PER_HZ);

    // Register byte offsets
    localparam logic [7:0]  ADR_CTRL           = 8'h00;
    localparam logic [7:0]  ADR_FREQ           = 8'h04;
    localparam logic [7:0]  ADR_CFG            = 8'h08;
    localparam logic [7:0]  ADR_STATUS         = 8'h0C;

    // Control fields
    localparam int          CTRL_EN_AUTH       = 0;
    localparam int          CTRL_FORCE_EN      = 1;
    localparam int          CTRL_SYNC_AUTH     = 2;
    localparam int          CTRL_FORCE_SYNC    = 3;
    localparam int          CTRL_W             = 4;

    // Configuration fields
    localparam int          CFG_SYNC_MAP       = 0;
    localparam int          CFG_SYNC_FILT_LO   = 1;
    localparam int          CFG_SYNC_EDGE_LO   = 4;
    localparam int          CFG_EN_MAP         = 6;
    localparam int          CFG_EN_FILT_LO     = 7;
    localparam int          CFG_W              = 10;

    // Status fields
    localparam int          STAT_AT_FREQ       = 0;
    localparam int          STAT_BUSY          = 1;
    localparam int          STAT_ERROR         = 2;
    localparam int          STAT_ENABLED       = 3;
    localparam int          STAT_OUT           = 4;
    localparam int          STAT_CODE_LO       = 8;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST     = 4'h0;
    localparam logic [31:0]       FREQ_RST     = 32'h0000_03E8;
    localparam logic [CFG_W-1:0]  CFG_RST      = 10'h000;

    // Physical input positions of the sync and enable pins
    localparam int          SYNC_PIN_IDX       = 2;
    localparam int          EN_PIN_IDX         = 4;

    // Debounce settings, in nanoseconds
    localparam int unsigned FILT_TIME_NS [8]   = '{2_000, 4_000, 12_000, 40_000,
                                                   120_000, 400_000, 1_200_000, 4_000_000};
    localparam int          FILT_CNT_W         = 20;

    typedef enum logic [7:0] {
        ERR_NONE  = 8'h00,
        ERR_RANGE = 8'h01
    } error_code_t;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_BOTH = 2'b10
    } sync_edge_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_FAULT = 2'b10
    } gen_state_t;

    // Least time rounds up to whole cycles
    function automatic int unsigned filt_cycles(input int idx);
        return (FILT_TIME_NS[idx] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : filt_cycles

endpackage : sqgen_pkg

/* square_wave_generator.sv */
// Purpose: Square-wave frequency generator with 50% duty, Wishbone registers.
// Assumes: Synchronous inputs, one 125 MHz clock, synchronous active-high reset.
// Notes:   Phase accumulator avoids a divider; edges jitter by one clock at most.
`timescale 1ns/1ps
module square_wave_generator #(
    parameter int          GEN_INDEX  = 0,
    parameter int          NUM_INPUTS = 8,
    parameter int unsigned FILT_CYC [8] = '{
        sqgen_pkg::filt_cycles(0), sqgen_pkg::filt_cycles(1),
        sqgen_pkg::filt_cycles(2), sqgen_pkg::filt_cycles(3),
        sqgen_pkg::filt_cycles(4), sqgen_pkg::filt_cycles(5),
        sqgen_pkg::filt_cycles(6), sqgen_pkg::filt_cycles(7)}
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output      logic [31:0]           wb_dat_o,
    output      logic                  wb_ack_o,
    // Physical inputs
    input  wire logic [NUM_INPUTS-1:0] phys_in_i,
    // Generator outputs
    output      logic                  square_out_o,
    output      logic                  at_target_frequency_o,
    output      logic                  busy_o,
    output      logic                  error_o,
    output      sqgen_pkg::error_code_t error_code_o,
    output      logic                  module_claimed_o
);
    import sqgen_pkg::*;

    // Refuse configurations the logic cannot serve
    if (GEN_INDEX < 0 || GEN_INDEX > 1) begin : g_bad_index
        $error("Only generator indices 0 and 1 exist");
    end
    if (NUM_INPUTS <= EN_PIN_IDX) begin : g_bad_inputs
        $error("Too few physical inputs for the enable pin");
    end

    // Debounce counts must fit the counter and be one cycle at least
    for (genvar f = 0; f < 8; f++) begin : g_chk_filt
        if (FILT_CYC[f] < 1 || FILT_CYC[f] > (1 << FILT_CNT_W)) begin : g_bad_filt
            $error("Debounce count outside what the counter can time");
        end
    end

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Registers
    logic [CTRL_W-1:0] ctrl_r;
    logic [31:0]       freq_r;
    logic [CFG_W-1:0]  cfg_r;
    logic              ack_r;
    logic [31:0]       rd_dat_r;

    // Bus decode
    wire        bus_req   = wb_cyc_i & wb_stb_i;
    wire        wr_en     = bus_req & wb_we_i & ack_r;
    wire        rd_load   = bus_req & ~ack_r;
    wire [31:0] ctrl_wide = {{(32-CTRL_W){1'b0}}, ctrl_r};
    wire [31:0] cfg_wide  = {{(32-CFG_W){1'b0}}, cfg_r};
    wire [31:0] ctrl_nxt  = merge_bytes(ctrl_wide, wb_dat_i, wb_sel_i);
    wire [31:0] freq_nxt  = merge_bytes(freq_r, wb_dat_i, wb_sel_i);
    wire [31:0] cfg_nxt   = merge_bytes(cfg_wide, wb_dat_i, wb_sel_i);

    // Control fields
    wire        en_auth    = ctrl_r[CTRL_EN_AUTH];
    wire        force_en   = ctrl_r[CTRL_FORCE_EN];
    wire        sync_auth  = ctrl_r[CTRL_SYNC_AUTH];
    wire        force_sync = ctrl_r[CTRL_FORCE_SYNC];
    wire        sync_map   = cfg_r[CFG_SYNC_MAP];
    wire        en_map     = cfg_r[CFG_EN_MAP];
    wire [1:0]  sync_edge  = cfg_r[CFG_SYNC_EDGE_LO +: 2];
    wire [2:0]  filt_sel [2];
    assign filt_sel[0] = cfg_r[CFG_SYNC_FILT_LO +: 3];
    assign filt_sel[1] = cfg_r[CFG_EN_FILT_LO +: 3];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    // Writes land on the edge at which the master sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
            freq_r <= FREQ_RST;
            cfg_r  <= CFG_RST;
        end else if (wr_en) begin
            if (wb_adr_i == ADR_CTRL) begin
                ctrl_r <= ctrl_nxt[CTRL_W-1:0];
            end
            if (wb_adr_i == ADR_FREQ) begin
                freq_r <= freq_nxt;
            end
            if (wb_adr_i == ADR_CFG) begin
                cfg_r <= cfg_nxt[CFG_W-1:0];
            end
        end
    end

    // Debounce of sync (0) and enable (1) pins
    logic [1:0] pin_raw;
    logic [1:0] pin_filt;
    assign pin_raw[0] = phys_in_i[SYNC_PIN_IDX];
    assign pin_raw[1] = phys_in_i[EN_PIN_IDX];

    for (genvar ch = 0; ch < 2; ch++) begin : g_filt
        logic [FILT_CNT_W-1:0] cnt_r;
        logic                  filt_r;
        wire  [FILT_CNT_W-1:0] limit = FILT_CNT_W'(FILT_CYC[filt_sel[ch]] - 1);
        // Input must hold its new level for the whole setting before it passes
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cnt_r  <= '0;
                // Start at the pin's level so no false edge follows reset
                filt_r <= pin_raw[ch];
            end else if (pin_raw[ch] == filt_r) begin
                cnt_r <= '0;
            end else if (cnt_r >= limit) begin
                cnt_r  <= '0;
                filt_r <= pin_raw[ch];
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
        assign pin_filt[ch] = filt_r;
    end

    // Edge detection
    logic sync_d_r;
    logic fsync_d_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_d_r  <= pin_filt[0];
            fsync_d_r <= 1'b0;
        end else begin
            sync_d_r  <= pin_filt[0];
            fsync_d_r <= force_sync;
        end
    end

    wire sync_rise  = pin_filt[0] & ~sync_d_r;
    wire sync_fall  = ~pin_filt[0] & sync_d_r;
    wire edge_match = (sync_edge == EDGE_RISE) ? sync_rise :
                      (sync_edge == EDGE_FALL) ? sync_fall :
                      (sync_rise | sync_fall);
    wire sync_hit   = sync_auth & sync_map & edge_match;
    wire fsync_rise = force_sync & ~fsync_d_r;
    wire restart    = sync_hit | fsync_rise;

    wire enabled  = force_en | (en_auth & en_map & pin_filt[1]);
    wire range_ok = (freq_r >= FREQ_MIN) && (freq_r <= FREQ_MAX);

    // Generator core
    gen_state_t  state_r;
    logic [31:0] acc_r;
    logic [31:0] active_r;
    logic        out_r;
    wire  [31:0] acc_sum = acc_r + active_r;
    wire         tick    = acc_sum >= ACC_WRAP;

    // A new frequency from idle starts at once; a change while running
    // waits for the next half-period edge so no runt pulse appears.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r  <= ST_IDLE;
            acc_r    <= '0;
            active_r <= FREQ_RST;
            out_r    <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (enabled && range_ok) begin
                        state_r  <= ST_RUN;
                        acc_r    <= '0;
                        active_r <= freq_r;
                        out_r    <= 1'b1;
                    end else if (enabled) begin
                        state_r <= ST_FAULT;
                    end
                end
                ST_RUN: begin
                    if (!enabled) begin
                        state_r <= ST_IDLE;
                        out_r   <= 1'b0;
                    end else if (!range_ok) begin
                        state_r <= ST_FAULT;
                        out_r   <= 1'b0;
                    end else if (restart) begin
                        acc_r    <= '0;
                        active_r <= freq_r;
                        out_r    <= 1'b1;
                    end else if (tick) begin
                        acc_r    <= acc_sum - ACC_WRAP;
                        active_r <= freq_r;
                        out_r    <= ~out_r;
                    end else begin
                        acc_r <= acc_sum;
                    end
                end
                ST_FAULT: begin
                    if (!enabled) begin
                        state_r <= ST_IDLE;
                    end else if (range_ok) begin
                        state_r  <= ST_RUN;
                        acc_r    <= '0;
                        active_r <= freq_r;
                        out_r    <= 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    out_r   <= 1'b0;
                end
            endcase
        end
    end

    wire running  = (state_r == ST_RUN);
    wire at_freq  = running && (active_r == freq_r);
    wire fault    = (state_r == ST_FAULT);
    wire busy     = enabled && running && !at_freq;

    assign square_out_o          = out_r;
    assign at_target_frequency_o = at_freq;
    assign busy_o                = busy;
    assign error_o               = fault;
    assign error_code_o          = fault ? ERR_RANGE : ERR_NONE;

    // Claims its expert module from the first cycle after reset, whatever the configuration
    logic claimed_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            claimed_r <= 1'b0;
        end else begin
            claimed_r <= 1'b1;
        end
    end
    assign module_claimed_o = claimed_r;

    // Status view and read mux
    logic [31:0] status_word;
    always_comb begin
        status_word                            = '0;
        status_word[STAT_AT_FREQ]              = at_freq;
        status_word[STAT_BUSY]                 = busy;
        status_word[STAT_ERROR]                = fault;
        status_word[STAT_ENABLED]              = enabled;
        status_word[STAT_OUT]                  = out_r;
        status_word[STAT_CODE_LO +: 8]         = error_code_o;
    end

    wire [31:0] rd_mux = (wb_adr_i == ADR_CTRL)   ? ctrl_wide :
                         (wb_adr_i == ADR_FREQ)   ? freq_r :
                         (wb_adr_i == ADR_CFG)    ? cfg_wide :
                         (wb_adr_i == ADR_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_dat_r <= '0;
        end else if (rd_load) begin
            rd_dat_r <= rd_mux;
        end
    end

    assign wb_dat_o = rd_dat_r;
    assign wb_ack_o = ack_r;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_range_fault;
        enabled && !range_ok |=> fault && error_code_o == ERR_RANGE && !out_r;
    endproperty
    a_range_fault: assert property (p_range_fault) else $error("bad freq not faulted");

    property p_sync_restart;
        running && enabled && range_ok && sync_hit |=> out_r && acc_r == 32'h0000_0000;
    endproperty
    a_sync_restart: assert property (p_sync_restart) else $error("sync did not restart");

    property p_force_sync;
        running && enabled && range_ok && $rose(force_sync) ##1 1'b1 |-> out_r;
    endproperty
    a_force_sync: assert property (p_force_sync) else $error("force sync ignored");

    property p_force_en;
        force_en |-> enabled;
    endproperty
    a_force_en: assert property (p_force_en) else $error("forced enable lost");

    property p_at_freq;
        at_target_frequency_o |-> running && active_r == freq_r && !error_o;
    endproperty
    a_at_freq: assert property (p_at_freq) else $error("at-frequency wrong");

    property p_busy;
        busy_o |-> enabled && !at_target_frequency_o && !error_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy with done state");

    property p_start_no_busy;
        state_r == ST_IDLE && enabled && range_ok |=> !busy_o && at_target_frequency_o;
    endproperty
    a_start_no_busy: assert property (p_start_no_busy) else $error("busy on start");

    property p_out_low_idle;
        !running |-> !square_out_o;
    endproperty
    a_out_low_idle: assert property (p_out_low_idle) else $error("output while stopped");

    property p_toggle_cause;
        running && $past(running) && $changed(out_r) |-> $past(tick) || $past(restart);
    endproperty
    a_toggle_cause: assert property (p_toggle_cause) else $error("stray output edge");

    property p_busy_on_change;
        running && wr_en && wb_adr_i == ADR_FREQ && freq_nxt != active_r && !tick && !restart
            |=> busy_o || !running || !enabled;
    endproperty
    a_busy_on_change: assert property (p_busy_on_change) else $error("busy missed");

    property p_stop_on_disable;
        running && !enabled |=> !running && !square_out_o && !busy_o;
    endproperty
    a_stop_on_disable: assert property (p_stop_on_disable) else $error("still running");

    property p_start_output;
        state_r == ST_IDLE && enabled && range_ok |=> running && square_out_o;
    endproperty
    a_start_output: assert property (p_start_output) else $error("no start");

endmodule : square_wave_generator

/* square_wave_generator_tb.sv */
// Purpose: Self-checking bench for the square-wave generator.
// Assumes: Short debounce table; one Wishbone access at a time.
// Notes:   Fast frequencies keep half periods to 625 or 1250 cycles.
`timescale 1ns/1ps
module square_wave_generator_tb;
    import sqgen_pkg::*;
    localparam logic [31:0] FEN = 32'h0000_0002;
    localparam logic [31:0] F500K = 32'h0007_A120;
    // Sync cases: config, control, pin level, restart expected
    localparam logic [31:0] SC_CFG [9] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0011,
        32'h0000_0011, 32'h0000_0021, 32'h0000_0021, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0001};
    localparam logic [8:0]  SC_AUTH = 9'h0FF;
    localparam logic [8:0]  SC_PIN  = 9'h155;
    localparam logic [8:0]  SC_EXP  = 9'h039;

    logic              clk_i    = 1'b0;
    logic              rst_i    = 1'b1;
    logic              wb_cyc_i = 1'b0;
    logic              wb_stb_i = 1'b0;
    logic              wb_we_i  = 1'b0;
    logic [7:0]        wb_adr_i = 8'h00;
    logic [3:0]        wb_sel_i = 4'h0;
    logic [31:0]       wb_dat_i = 32'h0000_0000;
    logic [7:0]        phys_in_i = 8'h00;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic              square_out_o;
    logic              at_target_frequency_o;
    logic              busy_o;
    logic              error_o;
    error_code_t       error_code_o;
    logic              module_claimed_o;
    int                err_total   = 0;
    int                checks_done = 0;

    square_wave_generator #(
        .GEN_INDEX (0),
        .NUM_INPUTS(8),
        .FILT_CYC  ('{2, 3, 4, 5, 6, 7, 8, 9})
    ) i_dut (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .wb_cyc_i             (wb_cyc_i),
        .wb_stb_i             (wb_stb_i),
        .wb_we_i              (wb_we_i),
        .wb_adr_i             (wb_adr_i),
        .wb_sel_i             (wb_sel_i),
        .wb_dat_i             (wb_dat_i),
        .wb_dat_o             (wb_dat_o),
        .wb_ack_o             (wb_ack_o),
        .phys_in_i            (phys_in_i),
        .square_out_o         (square_out_o),
        .at_target_frequency_o(at_target_frequency_o),
        .busy_o               (busy_o),
        .error_o              (error_o),
        .error_code_o         (error_code_o),
        .module_claimed_o     (module_claimed_o)
    );

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic summarize();
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : cmp32

    task automatic cmp1(input logic got, input logic exp, input string msg);
        cmp32({31'h0000_0000, got}, {31'h0000_0000, exp}, msg);
    endtask : cmp1

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic pin(input logic [7:0] v);
        @(posedge clk_i);
        phys_in_i <= v;
    endtask : pin

    // Master holds the request until ack is sampled, then releases
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (wb_ack_o !== 1'b1) cmp1(1'b0, 1'b1, "no bus ack");
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic en_chk(input logic exp);
        logic [31:0] q;
        wb(1'b0, ADR_STATUS, 32'h0000_0000, q);
        cmp1(q[STAT_ENABLED], exp, "enabled status");
    endtask : en_chk

    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (square_out_o !== v && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (square_out_o !== v) cmp1(1'b0, 1'b1, "output edge missing");
    endtask : wait_lvl

    // Length of the next full level v, in cycles
    task automatic meas(input logic v, output int n);
        wait_lvl(~v);
        wait_lvl(v);
        n = 0;
        while (square_out_o === v && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
    endtask : meas

    task automatic t_reset();
        logic [31:0] q;
        wb(1'b0, ADR_CTRL, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0000, "ctrl reset");
        wb(1'b0, ADR_CFG, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0000, "cfg reset");
        wb(1'b0, ADR_STATUS, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0000, "status reset");
        wb(1'b0, 8'h10, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0000, "unmapped read");
        cmp1(module_claimed_o, 1'b1, "module claim");
    endtask : t_reset

    task automatic t_run();
        int n;
        wr(ADR_FREQ, FREQ_MAX);
        wr(ADR_CTRL, FEN);
        tick(2);
        cmp1(square_out_o, 1'b1, "forced start");
        cmp1(at_target_frequency_o, 1'b1, "at freq on start");
        cmp1(busy_o, 1'b0, "busy on immediate start");
        meas(1'b0, n);
        cmp32(32'(n), 32'h0000_0271, "low time at max");
        meas(1'b1, n);
        cmp32(32'(n), 32'h0000_0271, "high time at max");
    endtask : t_run

    task automatic t_change();
        int n;
        wr(ADR_FREQ, F500K);
        tick(1);
        cmp1(busy_o, 1'b1, "busy during change");
        cmp1(at_target_frequency_o, 1'b0, "at freq during change");
        wait_lvl(~square_out_o);
        tick(1);
        cmp1(busy_o, 1'b0, "busy after change");
        cmp1(at_target_frequency_o, 1'b1, "at freq after change");
        meas(1'b1, n);
        cmp32(32'(n), 32'h0000_04E2, "high time at 50 kHz");
        // Right after an edge, so the slow value never gets applied
        wr(ADR_FREQ, FREQ_MIN);
        tick(2);
        cmp1(error_o, 1'b0, "minimum accepted");
        wr(ADR_FREQ, F500K);
    endtask : t_change

    task automatic t_range();
        logic [31:0] q;
        int          n;
        for (int i = 0; i < 2; i++) begin
            wr(ADR_FREQ, (i == 0) ? 32'h0000_0000 : FREQ_MAX + 32'h0000_0001);
            tick(2);
            cmp1(error_o, 1'b1, "range error flag");
            cmp32(32'(error_code_o), 32'(ERR_RANGE), "range error code");
            cmp1(busy_o, 1'b0, "busy on error");
            wb(1'b0, ADR_STATUS, 32'h0000_0000, q);
            cmp32(q & 32'h0000_FF04, {16'h0000, ERR_RANGE, 8'h04}, "status error");
            n = 0;
            repeat (1400) begin
                @(posedge clk_i);
                if (square_out_o !== 1'b0) n++;
            end
            cmp32(32'(n), 32'h0000_0000, "output while invalid");
            wr(ADR_FREQ, FREQ_MAX);
            tick(2);
            cmp1(error_o, 1'b0, "error cleared");
            cmp32(32'(error_code_o), 32'(ERR_NONE), "code cleared");
            cmp1(square_out_o, 1'b1, "restart after valid");
        end
    endtask : t_range

    task automatic t_disable();
        wr(ADR_CTRL, 32'h0000_0000);
        tick(2);
        cmp1(busy_o, 1'b0, "busy after disable");
        cmp1(at_target_frequency_o, 1'b0, "at freq after disable");
        en_chk(1'b0);
    endtask : t_disable

    task automatic t_enpin();
        // Longest short filter, nine cycles
        wr(ADR_CFG, 32'h0000_03C0);
        wr(ADR_CTRL, 32'h0000_0001);
        pin(8'h10);
        tick(2);
        pin(8'h00);
        tick(16);
        en_chk(1'b0);
        pin(8'h10);
        tick(3);
        en_chk(1'b0);
        tick(16);
        en_chk(1'b1);
        cmp1(at_target_frequency_o, 1'b1, "at freq by pin");
        pin(8'h00);
        tick(20);
        en_chk(1'b0);
        cmp1(busy_o, 1'b0, "busy after pin drop");
        pin(8'h10);
        wr(ADR_CFG, 32'h0000_0000);
        tick(20);
        en_chk(1'b0);
        wr(ADR_CFG, 32'h0000_0040);
        wr(ADR_CTRL, 32'h0000_0000);
        tick(20);
        en_chk(1'b0);
        wr(ADR_CTRL, FEN);
        pin(8'h00);
        tick(20);
        en_chk(1'b1);
    endtask : t_enpin

    task automatic t_sync();
        int n;
        wr(ADR_FREQ, F500K);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        tick(300);
        wr(ADR_CTRL, FEN | 32'h0000_0008);
        tick(2);
        cmp1(square_out_o, 1'b1, "forced restart");
        n = 0;
        while (square_out_o === 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        cmp1(n inside {[1240:1252]}, 1'b1, "fresh cycle length");
        for (int i = 0; i < 9; i++) begin
            wr(ADR_CFG, SC_CFG[i]);
            wr(ADR_CTRL, SC_AUTH[i] ? FEN | 32'h0000_0004 : FEN);
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            tick(300);
            pin(SC_PIN[i] ? 8'h04 : 8'h00);
            tick(12);
            cmp1(square_out_o, SC_EXP[i], "sync pin restart");
        end
    endtask : t_sync

    initial begin
        tick(20);
        rst_i <= 1'b0;
        t_reset();
        t_run();
        t_change();
        t_range();
        t_disable();
        t_enpin();
        t_sync();
        summarize();
    end

    // Whole sequence needs about 32k cycles
    initial begin
        tick(100000);
        err_total++;
        summarize();
    end
endmodule : square_wave_generator_tb
